// ==== hdl/ssac_master.sv ====
// master-station command controller: apb registers to servo command requests
`timescale 1ns/100ps
`default_nettype none
module ssac_master
  import ssac_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // command request toward the link layer
  output logic             req_valid_o,
  input  wire logic        req_ready_i,
  output logic [7:0]       req_cmd_o,
  output logic [7:0]       req_dno_o,
  output logic             req_has_data_o,
  output logic [31:0]      req_data_o,
  // reply from the link layer
  input  wire logic        rsp_valid_i,
  input  wire logic        rsp_err_i,
  input  wire logic [31:0] rsp_data_i,
  // external input signal enables
  output logic [31:0]      ext_in_o
);
  typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT} ssac_state_t;

  ssac_state_t state;
  ssac_state_t next_state;
  ssac_cmd_if  cif ();

  logic [3:0]  op;
  logic [3:0]  idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] outpin;
  logic [31:0] outdev;
  logic [31:0] ext_in;
  logic        done;
  logic        err;
  logic        reject;
  logic        no_alarm;

  function automatic logic [31:0] defined_bits(input logic [31:0] w, input logic [31:0] m);
    defined_bits = w & m;
  endfunction

  // apb decode
  wire access    = psel_i & penable_i;
  wire wr        = access & pwrite_i;
  wire hit_ctrl  = (paddr_i == OFS_CTRL);
  wire hit_stat  = (paddr_i == OFS_STATUS);
  wire hit_wdata = (paddr_i == OFS_WDATA);
  wire hit_rdata = (paddr_i == OFS_RDATA);
  wire hit_opin  = (paddr_i == OFS_OUTPIN);
  wire hit_odev  = (paddr_i == OFS_OUTDEV);
  wire hit_ext   = (paddr_i == OFS_EXTIN);
  wire mapped    = hit_ctrl | hit_stat | hit_wdata | hit_rdata | hit_opin | hit_odev | hit_ext;

  wire busy      = (state != S_IDLE);
  wire kick      = wr & hit_ctrl;
  // a start while busy is refused, not queued
  wire start     = kick & ~busy & cif.legal;
  wire refuse    = kick & (busy | ~cif.legal);
  wire sent      = (state == S_SEND) & req_ready_i;
  wire finish    = (state == S_WAIT) & rsp_valid_i;
  wire good_done = finish & ~rsp_err_i;
  wire clr_done  = wr & hit_stat & pwdata_i[ST_DONE];
  wire clr_err   = wr & hit_stat & pwdata_i[ST_ERR];
  wire clr_rej   = wr & hit_stat & pwdata_i[ST_REJECT];

  wire [3:0] ctrl_op  = pwdata_i[CTRL_OP_LSB +: 4];
  wire [3:0] ctrl_idx = pwdata_i[CTRL_IDX_LSB +: 4];

  // encoder sees the requested op while idle, the held op afterwards
  assign cif.op    = busy ? op    : ctrl_op;
  assign cif.idx   = busy ? idx   : ctrl_idx;
  assign cif.wdata = wdata;

  ssac_encode u_enc (
    .c (cif)
  );

  wire is_alarm_op = (op == OP_ALMNO) | (op == OP_CURALM);
  wire devset_ok   = good_done & (op == OP_DEVSET);
  // bits the master turns off also leave the external inputs
  wire [31:0] dropped = ~wdata & MASK_DEVSET;

  wire [31:0] status_word = {27'h0, no_alarm, reject, err, done, busy};
  wire [31:0] read_mux =
      hit_ctrl  ? {24'h0, idx, op} :
      hit_stat  ? status_word :
      hit_wdata ? wdata :
      hit_rdata ? rdata :
      hit_opin  ? outpin :
      hit_odev  ? outdev :
      hit_ext   ? ext_in : RST_WORD;

  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;
  assign prdata_o  = read_mux;
  assign ext_in_o  = ext_in;

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (start) next_state = S_SEND;
      S_SEND: if (req_ready_i) next_state = S_WAIT;
      S_WAIT: if (rsp_valid_i) next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // held operation and index
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op  <= 4'h0;
      idx <= 4'h0;
    end else if (start) begin
      op  <= ctrl_op;
      idx <= ctrl_idx;
    end
  end

  // wdata is frozen while a frame is out
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdata <= RST_WORD;
    end else if (wr & hit_wdata & ~busy) begin
      wdata <= pwdata_i;
    end
  end

  // request outputs held from start until taken
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_valid_o    <= 1'b0;
      req_cmd_o      <= 8'h00;
      req_dno_o      <= 8'h00;
      req_has_data_o <= 1'b0;
      req_data_o     <= RST_WORD;
    end else if (start) begin
      req_valid_o    <= 1'b1;
      req_cmd_o      <= cif.cmd;
      req_dno_o      <= cif.dno;
      req_has_data_o <= cif.has_data;
      req_data_o     <= cif.data;
    end else if (sent) begin
      req_valid_o    <= 1'b0;
    end
  end

  // reply capture; rdata keeps the raw reply, unassigned bits of the pin and device words cleared before software sees them
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata  <= RST_WORD;
      outpin <= RST_WORD;
      outdev <= RST_WORD;
    end else if (good_done) begin
      rdata <= rsp_data_i;
      if (op == OP_OUTPIN) outpin <= defined_bits(rsp_data_i, MASK_OUTPIN);
      if (op == OP_OUTDEV) outdev <= defined_bits(rsp_data_i, MASK_OUTDEV);
    end
  end

  // external input enables: software sets, a confirmed off-switch drops
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_in <= RST_WORD;
    end else if (devset_ok) begin
      ext_in <= ext_in & ~dropped;
    end else if (wr & hit_ext) begin
      ext_in <= defined_bits(pwdata_i, MASK_DEVSET);
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done     <= 1'b0;
      err      <= 1'b0;
      reject   <= 1'b0;
      no_alarm <= 1'b0;
    end else begin
      done   <= good_done | (done & ~clr_done);
      err    <= (finish & rsp_err_i) | (err & ~clr_err);
      reject <= refuse | (reject & ~clr_rej);
      if (good_done & is_alarm_op) begin
        no_alarm <= (rsp_data_i[15:0] == NO_ALARM);
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_req_hold_stable: assert property (
    req_valid_o & ~req_ready_i |=> req_valid_o & $stable(req_cmd_o) & $stable(req_dno_o) & $stable(req_data_o)
  ) else $error("request changed before it was taken");

  a_pin_word_cmd: assert property (
    start & (ctrl_op == OP_OUTPIN) |=> req_cmd_o == 8'h12 && req_dno_o == 8'hc0 && !req_has_data_o
  ) else $error("output pin read badly encoded");

  a_dev_word_cmd: assert property (
    start & (ctrl_op == OP_OUTDEV) |=> req_cmd_o == 8'h12 && req_dno_o == 8'h80
  ) else $error("output device read badly encoded");

  a_onoff_masked: assert property (
    req_valid_o & (req_cmd_o == 8'h92) |-> req_dno_o == 8'h60 && req_has_data_o && (req_data_o & 32'hf800_e780) == 32'h0
  ) else $error("on/off word carries unassigned bits");

  a_clear_key: assert property (
    req_valid_o & (req_cmd_o == 8'h82) |-> req_data_o == 32'h0000_1ea5 && (req_dno_o == 8'h00 || req_dno_o == 8'h20)
  ) else $error("clear sent without key");

  a_hist_range: assert property (
    req_valid_o & (req_cmd_o == 8'h33) |-> (req_dno_o >= 8'h10 && req_dno_o <= 8'h15) || (req_dno_o >= 8'h20 && req_dno_o <= 8'h25)
  ) else $error("history number out of range");

  a_table_range: assert property (
    req_valid_o & (req_cmd_o inside {8'h40, 8'h50, 8'h54, 8'h58}) |-> req_dno_o >= 8'h01 && req_dno_o <= 8'h0f
  ) else $error("point table number out of range");

  a_disp_range: assert property (
    req_valid_o & (req_cmd_o == 8'h35) |-> req_dno_o >= 8'h80 && req_dno_o <= 8'h8e
  ) else $error("display number out of range");

  a_reject_no_send: assert property (
    refuse & ~busy |=> !req_valid_o ##1 !req_valid_o && reject
  ) else $error("refused order still went out");

  a_outpin_zero: assert property (
    (outpin & ~32'h0000_007f) == 32'h0 && (outdev & ~32'h000f_0da9) == 32'h0
  ) else $error("unassigned status bit set");

  a_ext_drop: assert property (
    devset_ok |=> (ext_in & ~$past(wdata) & 32'h07ff_187f) == 32'h0
  ) else $error("external input left on after switch-off");

  // every order but on/off checked against its own codes, not the encoder's tables; on/off only by its data word
  a_almno_cmd: assert property (
    start & (ctrl_op == OP_ALMNO) |=> req_cmd_o == 8'h33 && req_dno_o == 8'h10 + {4'h0, $past(ctrl_idx)}
  ) else $error("alarm number read badly encoded");

  a_almtime_cmd: assert property (
    start & (ctrl_op == OP_ALMTIME) |=> req_cmd_o == 8'h33 && req_dno_o == 8'h20 + {4'h0, $past(ctrl_idx)}
  ) else $error("alarm hours read badly encoded");

  a_histclr_cmd: assert property (
    start & (ctrl_op == OP_HISTCLR) |=> req_cmd_o == 8'h82 && req_dno_o == 8'h20 && req_has_data_o
  ) else $error("history clear badly encoded");

  a_curalm_cmd: assert property (
    start & (ctrl_op == OP_CURALM) |=> req_cmd_o == 8'h02 && req_dno_o == 8'h00 && !req_has_data_o
  ) else $error("current alarm read badly encoded");

  a_disp_cmd: assert property (
    start & (ctrl_op == OP_ALMDISP) |=> req_cmd_o == 8'h35 && req_dno_o == 8'h80 + {4'h0, $past(ctrl_idx)}
  ) else $error("alarm display read badly encoded");

  a_curclr_cmd: assert property (
    start & (ctrl_op == OP_CURCLR) |=> req_cmd_o == 8'h82 && req_dno_o == 8'h00 && req_has_data_o
  ) else $error("current alarm clear badly encoded");

  a_pos_cmd: assert property (
    start & (ctrl_op == OP_POS) |=> req_cmd_o == 8'h40 && req_dno_o == {4'h0, $past(ctrl_idx)}
  ) else $error("position read badly encoded");

  a_spd_cmd: assert property (
    start & (ctrl_op == OP_SPD) |=> req_cmd_o == 8'h50 && req_dno_o == {4'h0, $past(ctrl_idx)}
  ) else $error("speed read badly encoded");

  a_acc_cmd: assert property (
    start & (ctrl_op == OP_ACC) |=> req_cmd_o == 8'h54 && req_dno_o == {4'h0, $past(ctrl_idx)}
  ) else $error("acceleration read badly encoded");

  a_dec_cmd: assert property (
    start & (ctrl_op == OP_DEC) |=> req_cmd_o == 8'h58 && req_dno_o == {4'h0, $past(ctrl_idx)}
  ) else $error("deceleration read badly encoded");

  a_devset_data: assert property (
    start & (ctrl_op == OP_DEVSET) |=> req_has_data_o && req_data_o == ($past(wdata) & 32'h07ff_187f)
  ) else $error("on/off word not taken from the data register");

  a_taken_drop: assert property (
    sent |=> !req_valid_o
  ) else $error("request still offered after it was taken");

  a_busy_refuse: assert property (
    kick & busy |=> $stable(req_cmd_o) && $stable(req_dno_o) && $stable(req_data_o)
  ) else $error("order written while busy changed the request");
endmodule
`default_nettype wire

// ==== hdl/ssac_pkg.sv ====
// constants, codes and register map of the servo master command controller
// Operation
// - output pin word: command 12, number C0
// - output device word: command 12, number 80
// - device on/off: command 92, number 60
// - switched-off device: drop external input too
// - alarm history numbers: command 33, 10..15
// - alarm hours: command 33, 20..25
// - history clear: 82, number 20, 1EA5
// - current alarm: command 02, number 00
// - alarm-time display: command 35, 80..8E
// - current alarm clear: 82, 00, 1EA5
// - position read: command 40, 01..0F
// - speed read: command 50, 01..0F
// - acceleration read: command 54, 01..0F
// - deceleration read: command 58, 01..0F
package ssac_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0c;
  localparam logic [7:0] OFS_OUTPIN = 8'h10;
  localparam logic [7:0] OFS_OUTDEV = 8'h14;
  localparam logic [7:0] OFS_EXTIN  = 8'h18;
  // ctrl fields
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_IDX_LSB = 4;
  // status bits, w1c except busy and no_alarm
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_ERR      = 2;
  localparam int ST_REJECT   = 3;
  localparam int ST_NO_ALARM = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // commands and data numbers
  localparam logic [7:0] CMD_STATUS  = 8'h12;
  localparam logic [7:0] CMD_DEVSET  = 8'h92;
  localparam logic [7:0] CMD_HIST    = 8'h33;
  localparam logic [7:0] CMD_CLEAR   = 8'h82;
  localparam logic [7:0] CMD_CURALM  = 8'h02;
  localparam logic [7:0] CMD_ALMDISP = 8'h35;
  localparam logic [7:0] CMD_POS     = 8'h40;
  localparam logic [7:0] CMD_SPD     = 8'h50;
  localparam logic [7:0] CMD_ACC     = 8'h54;
  localparam logic [7:0] CMD_DEC     = 8'h58;
  localparam logic [7:0] DNO_OUTPIN  = 8'hc0;
  localparam logic [7:0] DNO_OUTDEV  = 8'h80;
  localparam logic [7:0] DNO_DEVSET  = 8'h60;
  localparam logic [7:0] DNO_ALMNO   = 8'h10;
  localparam logic [7:0] DNO_ALMTIME = 8'h20;
  localparam logic [7:0] DNO_HISTCLR = 8'h20;
  localparam logic [7:0] DNO_CURALM  = 8'h00;
  localparam logic [7:0] DNO_CURCLR  = 8'h00;
  localparam logic [7:0] DNO_DISP    = 8'h80;
  localparam logic [3:0] HIST_LAST   = 4'h5;
  localparam logic [3:0] DISP_LAST   = 4'he;
  localparam logic [3:0] TABLE_FIRST = 4'h1;
  localparam logic [31:0] CLEAR_KEY  = 32'h0000_1ea5;
  localparam logic [15:0] NO_ALARM   = 16'h00ff;
  // defined bits of each status and on/off word
  localparam logic [31:0] MASK_OUTPIN = 32'h0000_007f;
  localparam logic [31:0] MASK_OUTDEV = 32'h000f_0da9;
  localparam logic [31:0] MASK_DEVSET = 32'h07ff_187f;
  typedef enum logic [3:0] {
    OP_OUTPIN, OP_OUTDEV, OP_DEVSET, OP_ALMNO, OP_ALMTIME, OP_HISTCLR,
    OP_CURALM, OP_ALMDISP, OP_CURCLR, OP_POS, OP_SPD, OP_ACC, OP_DEC
  } ssac_op_t;
endpackage

// ==== hdl/ssac_cmd_if.sv ====
// operation-to-frame carrier between controller and encoder
`timescale 1ns/100ps
`default_nettype none
interface ssac_cmd_if;
  logic [3:0]  op;
  logic [3:0]  idx;
  logic [31:0] wdata;
  logic [7:0]  cmd;
  logic [7:0]  dno;
  logic [31:0] data;
  logic        has_data;
  logic        legal;
  modport ctl (output op, idx, wdata, input cmd, dno, data, has_data, legal);
  modport enc (input op, idx, wdata, output cmd, dno, data, has_data, legal);
endinterface
`default_nettype wire

// ==== hdl/ssac_encode.sv ====
// maps an operation and index onto command code, data number and data
`timescale 1ns/100ps
`default_nettype none
module ssac_encode
  import ssac_pkg::*;
(
  ssac_cmd_if.enc c
);
  wire hist_ok  = (c.idx <= HIST_LAST);
  wire disp_ok  = (c.idx <= DISP_LAST);
  wire table_ok = (c.idx >= TABLE_FIRST);
  wire [7:0] idx8 = {4'h0, c.idx};

  always_comb begin
    c.cmd      = CMD_STATUS;
    c.dno      = DNO_OUTPIN;
    c.data     = RST_WORD;
    c.has_data = 1'b0;
    c.legal    = 1'b1;
    unique case (c.op)
      OP_OUTPIN:  c.dno = DNO_OUTPIN;
      OP_OUTDEV:  c.dno = DNO_OUTDEV;
      OP_DEVSET: begin
        c.cmd      = CMD_DEVSET;
        c.dno      = DNO_DEVSET;
        c.data     = c.wdata & MASK_DEVSET;
        c.has_data = 1'b1;
      end
      OP_ALMNO: begin
        c.cmd   = CMD_HIST;
        c.dno   = DNO_ALMNO + idx8;
        c.legal = hist_ok;
      end
      OP_ALMTIME: begin
        c.cmd   = CMD_HIST;
        c.dno   = DNO_ALMTIME + idx8;
        c.legal = hist_ok;
      end
      OP_HISTCLR: begin
        c.cmd      = CMD_CLEAR;
        c.dno      = DNO_HISTCLR;
        c.data     = CLEAR_KEY;
        c.has_data = 1'b1;
      end
      OP_CURALM: begin
        c.cmd = CMD_CURALM;
        c.dno = DNO_CURALM;
      end
      OP_ALMDISP: begin
        c.cmd   = CMD_ALMDISP;
        c.dno   = DNO_DISP + idx8;
        c.legal = disp_ok;
      end
      OP_CURCLR: begin
        c.cmd      = CMD_CLEAR;
        c.dno      = DNO_CURCLR;
        c.data     = CLEAR_KEY;
        c.has_data = 1'b1;
      end
      OP_POS: begin
        c.cmd   = CMD_POS;
        c.dno   = idx8;
        c.legal = table_ok;
      end
      OP_SPD: begin
        c.cmd   = CMD_SPD;
        c.dno   = idx8;
        c.legal = table_ok;
      end
      OP_ACC: begin
        c.cmd   = CMD_ACC;
        c.dno   = idx8;
        c.legal = table_ok;
      end
      OP_DEC: begin
        c.cmd   = CMD_DEC;
        c.dno   = idx8;
        c.legal = table_ok;
      end
      default: c.legal = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== testbench/ssac_slave_model.sv ====
// behavioural servo amplifier answering command frames
`timescale 1ns/100ps
`default_nettype none
module ssac_slave_model (
  // clock, reset and pacing
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  lag_i,
  // request side
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [7:0]  req_cmd_i,
  input  wire logic [7:0]  req_dno_i,
  input  wire logic [31:0] req_data_i,
  // reply side
  output logic             rsp_valid_o,
  output logic             rsp_err_o,
  output logic [31:0]      rsp_data_o,
  output logic [31:0]      dev_on_o
);
  logic [15:0] hist [6];
  logic [15:0] cur;
  logic [3:0]  cnt;
  logic [31:0] val;
  logic [31:0] vq;
  logic        err;
  logic        eq;
  logic        pend;
  wire  [3:0]  n = req_dno_i[3:0];
  always_comb begin
    err = 1'b0;
    val = 32'h0;
    case (req_cmd_i)
      8'h12: begin
        if (req_dno_i == 8'hc0) val = 32'h0000_0055;
        else if (req_dno_i == 8'h80) val = 32'h000a_0129;
        else err = 1'b1;
      end
      8'h92: err = req_dno_i != 8'h60;
      8'h33: val = req_dno_i[7:4] == 4'h1 ? {16'h0, hist[n]} : {16'h0, 16'h01f5 + 16'(n)};
      8'h02: val = {16'h0, cur};
      8'h35: val = 32'h0100_0000 | 32'(n);
      8'h40, 8'h50, 8'h54, 8'h58: val = {req_cmd_i, 16'h0, req_dno_i};
      8'h82: err = req_data_i != 32'h0000_1ea5 || (req_dno_i != 8'h00 && req_dno_i != 8'h20);
      default: err = 1'b1;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 4'h0;
      pend <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_err_o <= 1'b0;
      rsp_data_o <= 32'h0;
      dev_on_o <= 32'h0;
      vq <= 32'h0;
      eq <= 1'b0;
      cur <= 16'h0032;
      for (int i = 0; i < 6; i++) hist[i] <= 16'h0030 + 16'(i);
    end else begin
      cnt <= (!pend && !req_valid_i) ? 4'h0 : cnt + 4'h1;
      req_ready_o <= !pend && req_valid_i && !req_ready_o && cnt >= lag_i;
      rsp_valid_o <= 1'b0;
      // between replies the data bus toggles the last reply value every cycle
      rsp_data_o <= ~rsp_data_o;
      if (req_valid_i && req_ready_o) begin
        pend <= 1'b1;
        cnt <= 4'h0;
        vq <= val;
        eq <= err;
        if (!err && req_cmd_i == 8'h92) dev_on_o <= req_data_i;
        if (!err && req_cmd_i == 8'h82 && req_dno_i == 8'h20)
          for (int i = 0; i < 6; i++) hist[i] <= 16'h00ff;
        if (!err && req_cmd_i == 8'h82 && req_dno_i == 8'h00) cur <= 16'h00ff;
      end
      if (pend && cnt == lag_i) begin
        pend <= 1'b0;
        rsp_valid_o <= 1'b1;
        rsp_err_o <= eq;
        rsp_data_o <= vq;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ssac_master_bench.sv ====
// self-checking bench for the servo master command controller
`timescale 1ns/100ps
`default_nettype none
module ssac_master_bench
  import ssac_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  lag = 4'h0;
  logic [31:0] prdata_o, req_data_o, rsp_data_i, ext_in_o, dev_on, rdat, st, t_cd, t_data;
  logic        pready_o, pslverr_o, req_valid_o, req_ready_i, req_has_data_o, rsp_valid_i, rsp_err_i, rerr;
  logic [7:0]  req_cmd_o, req_dno_o;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_sent = 0;
  int          cyc = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  ssac_master DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .req_valid_o(req_valid_o), .req_ready_i(req_ready_i), .req_cmd_o(req_cmd_o),
    .req_dno_o(req_dno_o), .req_has_data_o(req_has_data_o), .req_data_o(req_data_o),
    .rsp_valid_i(rsp_valid_i), .rsp_err_i(rsp_err_i), .rsp_data_i(rsp_data_i), .ext_in_o(ext_in_o));
  ssac_slave_model slave (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .lag_i(lag), .req_valid_i(req_valid_o),
    .req_ready_o(req_ready_i), .req_cmd_i(req_cmd_o), .req_dno_i(req_dno_o), .req_data_i(req_data_o),
    .rsp_valid_o(rsp_valid_i), .rsp_err_o(rsp_err_i), .rsp_data_o(rsp_data_i), .dev_on_o(dev_on));
  // snoop of each frame handed to the link
  always @(posedge clk_sys_i) begin
    cyc++;
    if (req_valid_o && req_ready_i) begin
      t_cd <= {16'h0, req_cmd_o, req_dno_o};
      t_data <= req_has_data_o ? req_data_o : 32'hdead_0000;
      n_sent++;
    end
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // start an operation, wait for idle, keep and clear the sticky flags
  // a hang is caught by the cycle ceiling, which fails the run
  task automatic op(input logic [3:0] o, input logic [3:0] i);
    apb(1'b1, OFS_CTRL, {24'h0, i, o});
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end while (rdat[ST_BUSY] !== 1'b0);
    st = rdat;
    apb(1'b1, OFS_STATUS, 32'he);
  endtask
  task automatic t_status;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_EXTIN, 32'h0);
    op(4'h0, 4'h0);
    chk(t_cd, 32'h12c0);
    chk(t_data, 32'hdead_0000);
    rd(OFS_OUTPIN, 32'h55);
    op(4'h1, 4'h0);
    chk(t_cd, 32'h1280);
    rd(OFS_OUTDEV, 32'h000a_0129);
    $display("test status words done");
  endtask
  task automatic t_onoff;
    apb(1'b1, OFS_EXTIN, 32'hffff_ffff);
    apb(1'b1, OFS_WDATA, 32'hf8ad_0041);
    op(4'h2, 4'h0);
    chk(t_cd, 32'h9260);
    chk(t_data, 32'h00ad_0041);
    chk(dev_on, 32'h00ad_0041);
    rd(OFS_EXTIN, 32'h00ad_0041);
    chk(ext_in_o, 32'h00ad_0041);
    $display("test device on/off done");
  endtask
  task automatic t_alarm;
    for (int i = 0; i < 6; i++) begin
      op(4'h3, 4'(i));
      chk(t_cd, 32'h3310 + 32'(i));
      rd(OFS_RDATA, 32'h30 + 32'(i));
      op(4'h4, 4'(i));
      chk(t_cd, 32'h3320 + 32'(i));
      rd(OFS_RDATA, 32'h1f5 + 32'(i));
    end
    op(4'h6, 4'h0);
    chk(t_cd, 32'h0200);
    rd(OFS_RDATA, 32'h32);
    op(4'h8, 4'h0);
    chk({t_cd[15:0], t_data[15:0]}, 32'h8200_1ea5);
    op(4'h6, 4'h0);
    rd(OFS_RDATA, 32'hff);
    op(4'h5, 4'h0);
    chk({t_cd[15:0], t_data[15:0]}, 32'h8220_1ea5);
    op(4'h3, 4'h5);
    rd(OFS_RDATA, 32'hff);
    chk(st, 32'h12);
    $display("test alarm history done");
  endtask
  task automatic t_tables;
    logic [7:0] c;
    lag <= 4'h7;
    for (int i = 0; i < 2; i++) begin
      op(4'h7, i ? 4'he : 4'h0);
      rd(OFS_RDATA, i ? 32'h0100_000e : 32'h0100_0000);
      for (int o = 9; o < 13; o++) begin
        c = o == 9 ? 8'h40 : 8'h50 + 8'((o - 10) * 4);
        op(4'(o), i ? 4'hf : 4'h1);
        rd(OFS_RDATA, {c, 16'h0, i ? 8'h0f : 8'h01});
      end
    end
    lag <= 4'h0;
    $display("test display and point table done");
  endtask
  task automatic t_reject;
    int n0;
    n0 = n_sent;
    // no_alarm stays set from the emptied history
    op(4'h3, 4'h6);
    chk(st, 32'h18);
    op(4'h9, 4'h0);
    chk(st, 32'h18);
    op(4'hd, 4'h0);
    chk(st, 32'h18);
    chk(32'(n_sent - n0), 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk({31'h0, rerr}, 32'h1);
    $display("test refusals done");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_status();
    t_onoff();
    t_alarm();
    t_tables();
    t_reject();
    report_and_stop();
  end
endmodule
`default_nettype wire
